// ==== spicfg_pkg.sv ====
package spicfg_pkg;
   // Register placement in special function register space
   localparam logic [7:0] SPICFG_REG_ADDR = 8'h9A;
   localparam int SPICFG_BUSY_BIT = 7;
   localparam int SPICFG_ROLE_BIT = 6;
   localparam int SPICFG_PHASE_BIT = 5;
   localparam int SPICFG_POL_BIT = 4;
   localparam int SPICFG_SEL_BIT = 3;
   localparam int SPICFG_RAWSEL_BIT = 2;
   localparam int SPICFG_SHEMPTY_BIT = 1;
   localparam int SPICFG_RXEMPTY_BIT = 0;
   // Reset values of the writable fields and of the filtered select
   localparam logic SPICFG_ROLE_RST = 1'b0;
   localparam logic SPICFG_PHASE_RST = 1'b0;
   localparam logic SPICFG_POL_RST = 1'b0;
   localparam logic SPICFG_SEL_RST = 1'b1;
   // Select filter: the input must stand this long before the flag follows
   localparam int SPICFG_FILTER_NS = 120;
   localparam int SPICFG_CLK_NS = 40;
   localparam int SPICFG_FILTER_CYCLES = (SPICFG_FILTER_NS + SPICFG_CLK_NS - 1) / SPICFG_CLK_NS;
   localparam int SPICFG_FILTER_W = 3;

   // Control fields held by the register
   typedef struct packed {
      logic master_role_enable;
      logic clock_phase_select;
      logic clock_idle_polarity;
   } spicfg_ctrl_type;

   // Events reported by the shift engine and buffers
   typedef struct packed {
      logic transfer_active;
      logic tx_load;
      logic shift_done;
      logic rx_deliver;
      logic rx_read;
   } spicfg_event_type;

   // Roles of the serial port
   typedef enum logic {SPICFG_SLAVE, SPICFG_MASTER} spicfg_role_type;
endpackage

// ==== spicfg_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for a level from outside the clock domain
module spicfg_sync
   import spicfg_pkg::*;
#(
   // Level both stages take in reset, chosen as the pin's idle level
   parameter logic RESET_LEVEL = SPICFG_SEL_RST
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Level in and out
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;

   // First stage is read only by the second stage
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         meta_q <= RESET_LEVEL;
         sync_out <= RESET_LEVEL;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== spicfg_deglitch.sv ====
`timescale 1ns/1ps
// Holds its output until the input has stood stable for the filter time
module spicfg_deglitch
   import spicfg_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Synchronised level in, filtered level out
   input wire logic level_in,
   output logic level_out
);
   logic [SPICFG_FILTER_W-1:0] count_q;

   // A change must persist before it is accepted; short pulses are dropped
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         count_q <= '0;
         level_out <= SPICFG_SEL_RST;
      end
      else if (level_in == level_out)
         count_q <= '0;
      else if (count_q == SPICFG_FILTER_W'(SPICFG_FILTER_CYCLES - 1))
      begin
         count_q <= '0;
         level_out <= level_in;
      end
      else
         count_q <= count_q + 1'b1;
   end
endmodule

// ==== spicfg_reg.sv ====
`timescale 1ns/1ps
// Functional notes
// [R1] The busy flag reads 1 while a transfer runs, in either role, else 0.
// [R2] The role bit selects slave at 0 and master at 1.
// [R3] The phase bit centres data on the first clock edge at 0 and on the second at 1.
// [R4] The polarity bit sets the idle clock level, low at 0 and high at 1.
// [R5] The selected flag reads 1 while the active-low select input is low.
// [R6] The selected flag follows a filtered copy of the select input.
// [R7] The raw select bit returns the unfiltered select level at read time; here it is the synchronised level, two clocks behind the pin.
// [R8] In slave role the shifter-empty flag sets once nothing is left to shift or move.
// [R9] The shifter-empty flag clears on a transmit load or on a serial clock transition.
// [R10] In master role the shifter-empty flag reads 1.
// [R11] In slave role the receive-empty flag sets after the buffer is read with nothing new.
// [R12] The receive-empty flag clears while an unread new byte is in the buffer.
// [R13] In master role the receive-empty flag reads 1.
// [R14] In slave role incoming data is sampled in the centre of each bit.
// [R15] Writes to the status positions are ignored; only role, phase and polarity store.
// [R16] Status flags are updated on the system clock so reads return a stable byte.
module spicfg_reg
   import spicfg_pkg::*;
(
   // System clock and reset
   input wire logic clock,
   input wire logic reset,
   // Special function register access
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_write,
   input wire logic sfr_read,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Events from the shift engine and buffers
   input wire spicfg_event_type engine_events,
   // Serial pins seen by this block
   input wire logic slave_select_n,
   input wire logic serial_clock_in,
   // Control outputs to the shift engine
   output spicfg_ctrl_type ctrl,
   output logic sample_strobe,
   output logic sck_idle_level
);
   spicfg_ctrl_type ctrl_q;
   logic sel_sync;
   logic sel_filt;
   logic sck_sync;
   logic sck_prev_q;
   logic sck_edge;
   logic busy_q;
   logic shempty_q;
   logic rxempty_q;
   logic pending_rx_q;
   logic [7:0] rdata_q;

   // Decoded strobes and next values
   logic wr_hit;
   logic rd_hit;
   logic rd_miss;
   logic slave_role;
   logic sck_rise;
   logic sck_fall;
   logic sample_edge;
   logic shempty_clear;
   logic shempty_set;
   logic selected_flag;
   logic raw_select;
   spicfg_ctrl_type ctrl_d;
   logic [7:0] status_byte;
   logic [7:0] rdata_d;

   // Address match; one decode serves writes and both kinds of read
   function automatic logic own_address(input logic [7:0] addr);
      return (addr == SPICFG_REG_ADDR);
   endfunction

   // Sampling edge of the slave input. The leading edge leaves the idle level
   // and the trailing edge returns to it, so which physical edge samples
   // depends on both the phase and the polarity bit.
   function automatic logic is_sample_edge
   (
      input logic rise,
      input logic fall,
      input logic phase,
      input logic polarity
   );
      logic leading;
      logic trailing;
      leading = polarity ? fall : rise;
      trailing = polarity ? rise : fall;
      return phase ? trailing : leading;
   endfunction

   // Access qualifiers; any other address is a foreign read or write
   assign wr_hit = sfr_write && own_address(sfr_addr);
   assign rd_hit = sfr_read && own_address(sfr_addr);
   assign rd_miss = sfr_read && !own_address(sfr_addr);

   // Role decode shared by the strobe and both slave-only flags
   assign slave_role = !ctrl_q.master_role_enable; // [R2]

   // Select pin: synchronised for both the raw bit and the filter.
   // The raw bit therefore trails the pin by two clocks; reading the pin
   // directly would risk a metastable bit in the status byte.
   spicfg_sync u_sel_sync
   (
      .clock(clock),
      .reset(reset),
      .async_in(slave_select_n),
      .sync_out(sel_sync)
   );

   // Glitch filter on the select input. Pulses shorter than the filter
   // time never reach the selected flag or the sampling strobe.
   spicfg_deglitch u_sel_filter
   (
      .clock(clock),
      .reset(reset),
      .level_in(sel_sync),
      .level_out(sel_filt)
   );

   // Serial clock arrives from the link and is sampled like any pin
   // Reset to the idle level so that no false edge follows reset
   spicfg_sync
   #(
      .RESET_LEVEL(SPICFG_POL_RST)
   )
   u_sck_sync
   (
      .clock(clock),
      .reset(reset),
      .async_in(serial_clock_in),
      .sync_out(sck_sync)
   );

   // Edge finder on the synchronised serial clock
   always_ff @(posedge clock)
   begin
      if (reset)
         sck_prev_q <= SPICFG_POL_RST;
      else
         sck_prev_q <= sck_sync;
   end
   assign sck_edge = sck_prev_q ^ sck_sync;
   // Direction of the edge, for the phase and polarity decode
   assign sck_rise = sck_edge && sck_sync;
   assign sck_fall = sck_edge && !sck_sync;

   // Next value of the writable fields. Status positions of the write data
   // are dropped here, so software may write back a byte it has read.
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wr_hit)
      begin
         ctrl_d.master_role_enable = sfr_wdata[SPICFG_ROLE_BIT]; // [R2] [R15]
         ctrl_d.clock_phase_select = sfr_wdata[SPICFG_PHASE_BIT]; // [R3]
         ctrl_d.clock_idle_polarity = sfr_wdata[SPICFG_POL_BIT]; // [R4]
      end
   end

   // Writable fields
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         ctrl_q.master_role_enable <= SPICFG_ROLE_RST;
         ctrl_q.clock_phase_select <= SPICFG_PHASE_RST;
         ctrl_q.clock_idle_polarity <= SPICFG_POL_RST;
      end
      else
         ctrl_q <= ctrl_d;
   end
   assign ctrl = ctrl_q;
   assign sck_idle_level = ctrl_q.clock_idle_polarity; // [R4]

   // Sample at the bit centre: the leading edge at phase 0, the trailing at
   // phase 1. Only a selected slave samples; a master times its own bits.
   always_comb
   begin
      sample_edge = is_sample_edge(sck_rise, sck_fall, ctrl_q.clock_phase_select,
         ctrl_q.clock_idle_polarity);
      sample_strobe = 1'b0;
      if (slave_role && !sel_filt)
         sample_strobe = sample_edge; // [R3] [R14]
   end

   // Busy follows the engine in both roles, registered on the system clock.
   // The extra cycle of delay is traded for a byte that never changes
   // in the middle of a read.
   always_ff @(posedge clock)
   begin
      if (reset)
         busy_q <= 1'b0;
      else
         busy_q <= engine_events.transfer_active; // [R1] [R16]
   end

   // Shifter-empty events. A clear wins over a set in the same cycle: a load
   // or a clock edge means new work is pending, and losing that would let
   // software see an empty shifter in the middle of a byte.
   assign shempty_clear = engine_events.tx_load || sck_edge; // [R9]
   assign shempty_set = engine_events.shift_done && !engine_events.rx_deliver; // [R8]

   // Shifter empty flag, forced high in master role
   always_ff @(posedge clock)
   begin
      if (reset)
         shempty_q <= 1'b1;
      else if (!slave_role)
         shempty_q <= 1'b1; // [R10]
      else if (shempty_clear)
         shempty_q <= 1'b0; // [R9]
      else if (shempty_set)
         shempty_q <= 1'b1; // [R8]
   end

   // Unread byte marker: set by a delivery, cleared by the read that takes it.
   // Leaving the slave role discards it, since the master owns the buffer.
   always_ff @(posedge clock)
   begin
      if (reset)
         pending_rx_q <= 1'b0;
      else if (!slave_role)
         pending_rx_q <= 1'b0;
      else if (engine_events.rx_deliver)
         pending_rx_q <= 1'b1;
      else if (engine_events.rx_read)
         pending_rx_q <= 1'b0;
   end

   // Receive empty: a delivery in the same cycle as a read wins, so a new
   // byte arriving with the read is not lost
   always_ff @(posedge clock)
   begin
      if (reset)
         rxempty_q <= 1'b1;
      else if (!slave_role)
         rxempty_q <= 1'b1; // [R13]
      else if (engine_events.rx_deliver)
         rxempty_q <= 1'b0; // [R12]
      else if (engine_events.rx_read && pending_rx_q)
         rxempty_q <= 1'b1; // [R11]
   end

   // Select levels as software sees them: the flag is active high
   assign selected_flag = ~sel_filt; // [R5] [R6]
   assign raw_select = sel_sync; // [R7]

   // Status byte as it stands this cycle, assembled in bit order
   always_comb
   begin
      status_byte = 8'h00;
      status_byte[SPICFG_BUSY_BIT] = busy_q; // [R1]
      status_byte[SPICFG_ROLE_BIT] = ctrl_q.master_role_enable;
      status_byte[SPICFG_PHASE_BIT] = ctrl_q.clock_phase_select;
      status_byte[SPICFG_POL_BIT] = ctrl_q.clock_idle_polarity;
      status_byte[SPICFG_SEL_BIT] = selected_flag; // [R5] [R6]
      status_byte[SPICFG_RAWSEL_BIT] = raw_select; // [R7]
      status_byte[SPICFG_SHEMPTY_BIT] = shempty_q; // [R16]
      status_byte[SPICFG_RXEMPTY_BIT] = rxempty_q; // [R16]
   end

   // Next read data: the status byte on a hit, zero on a foreign address,
   // otherwise held. Capturing at the strobe costs a cycle of latency but
   // keeps the byte still while software looks at it.
   always_comb
   begin
      rdata_d = rdata_q;
      if (rd_hit)
         rdata_d = status_byte;
      else if (rd_miss)
         rdata_d = 8'h00; // Unmapped address reads zero
   end

   // Read data register
   always_ff @(posedge clock)
   begin
      if (reset)
         rdata_q <= 8'h00;
      else
         rdata_q <= rdata_d;
   end
   assign sfr_rdata = rdata_q;
endmodule

// ==== spicfg_reg_properties.sv ====
`timescale 1ns/1ps
// Port-level checks of the config and status register
module spicfg_reg_checker
   import spicfg_pkg::*;
(
   // Clock, reset and register access
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_write,
   input wire logic sfr_read,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // Control outputs
   input wire spicfg_ctrl_type ctrl,
   input wire logic sample_strobe,
   input wire logic sck_idle_level
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // Access steps shared by several properties
   sequence s_wr; sfr_write && sfr_addr == SPICFG_REG_ADDR; endsequence
   sequence s_rd; sfr_read && sfr_addr == SPICFG_REG_ADDR; endsequence
   sequence s_master_rd; ctrl.master_role_enable [*2] ##0 s_rd; endsequence
   property p_role; s_wr |=> ctrl.master_role_enable == $past(sfr_wdata[6]); endproperty
   a_role: assert property (p_role) else $error("role bit not stored");
   property p_phase; s_wr |=> ctrl.clock_phase_select == $past(sfr_wdata[5]); endproperty
   a_phase: assert property (p_phase) else $error("phase bit not stored");
   property p_idle; $stable(ctrl) [*2] |-> sck_idle_level == ctrl.clock_idle_polarity; endproperty
   a_idle: assert property (p_idle) else $error("idle level differs from polarity");
   property p_master; s_master_rd |=> sfr_rdata[1:0] == 2'b11; endproperty
   a_master: assert property (p_master) else $error("master flags not forced");
   property p_other_rd; sfr_read && sfr_addr != SPICFG_REG_ADDR |=> sfr_rdata == 8'h00; endproperty
   a_other_rd: assert property (p_other_rd) else $error("foreign read not zero");
   property p_other_wr; sfr_write && sfr_addr != SPICFG_REG_ADDR |=> $stable(ctrl); endproperty
   a_other_wr: assert property (p_other_wr) else $error("foreign write stored");
   property p_hold; !sfr_read |=> $stable(sfr_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   property p_strobe; sample_strobe |-> !ctrl.master_role_enable; endproperty
   a_strobe: assert property (p_strobe) else $error("sampling in master role");
endmodule

// ==== spicfg_far_master.sv ====
`timescale 1ns/1ps
// Far-side master: one frame of 16 clock half periods of 160 ns under a low select
module spicfg_far_master
(
   // Frame request in, pins out
   input wire logic start,
   output logic select_n,
   output logic sck
);
   // Idle: not selected, clock low and still between frames
   initial
   begin
      select_n = 1'b1;
      sck = 1'b0;
   end
   always @(posedge start)
   begin
      select_n = 1'b0;
      repeat (16) #160 sck = ~sck;
      #160 select_n = 1'b1;
   end
endmodule

// ==== spicfg_reg_bench.sv ====
`timescale 1ns/1ps
// Self-checking bench of the config and status register
module spicfg_reg_bench
   import spicfg_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_write = 1'b0;
   logic sfr_read = 1'b0;
   logic start = 1'b0;
   logic glitch = 1'b0;
   logic seen = 1'b0;
   logic far_select_n, sck, sample_strobe, sck_idle_level;
   logic [7:0] sfr_rdata, r;
   logic [7:0] exp_q[$], mask_q[$];
   spicfg_event_type ev = '0;
   spicfg_ctrl_type ctrl;
   integer errors = 0, checks_done = 0, strobes = 0, seed = 32'hDED748C8;
   // Design and far-side master; glitch pulls the select low for a moment
   spicfg_far_master far (.start(start), .select_n(far_select_n), .sck(sck));
   spicfg_reg DUT (.clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_write(sfr_write),
      .sfr_read(sfr_read), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .engine_events(ev),
      .slave_select_n(far_select_n & ~glitch), .serial_clock_in(sck), .ctrl(ctrl),
      .sample_strobe(sample_strobe), .sck_idle_level(sck_idle_level));
   always #20 clock = ~clock;
   task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      {sfr_addr, sfr_wdata, sfr_write} = {a, d, 1'b1};
      @(negedge clock);
      sfr_write = 1'b0;
   endtask
   // Reads note the expected byte and a mask of the bits that matter
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge clock);
      {sfr_addr, sfr_read} = {a, 1'b1};
      exp_q.push_back(e);
      mask_q.push_back(m);
      @(negedge clock);
      sfr_read = 1'b0;
   endtask
   task automatic pulse(input logic [3:0] m);
      @(negedge clock);
      ev[3:0] = m;
      @(negedge clock);
      ev[3:0] = 4'h0;
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Read data lands one edge after the strobe, so compare at the next falling edge
   always @(posedge clock)
      seen <= sfr_read & ~reset;
   always @(negedge clock)
   begin
      strobes = strobes + (sample_strobe === 1'b1);
      if (seen)
      begin
         check("status byte", sfr_rdata & mask_q[0], exp_q.pop_front() & mask_q[0]);
         void'(mask_q.pop_front());
      end
   end
   // Main sequence
   initial
   begin
      repeat (2) @(negedge clock);
      reset = 1'b0;
      rd(SPICFG_REG_ADDR, 8'h07, 8'hFF);
      for (int i = 0; i < 8; i++)
      begin
         r = $random(seed);
         wr(SPICFG_REG_ADDR, {r[7], i[2:0], r[3:0]});
         rd(SPICFG_REG_ADDR, {1'b0, i[2:0], 4'h7}, 8'hFF);
      end
      r = $random(seed) | 8'h01;
      wr(r, 8'h00);
      rd(r, 8'h00, 8'hFF);
      rd(SPICFG_REG_ADDR, 8'h70, 8'hF0);
      ev.transfer_active = 1'b1;
      rd(SPICFG_REG_ADDR, 8'h80, 8'h80);
      ev.transfer_active = 1'b0;
      rd(SPICFG_REG_ADDR, 8'h00, 8'h80);
      wr(SPICFG_REG_ADDR, 8'h00);
      pulse(4'h2);
      rd(SPICFG_REG_ADDR, 8'h00, 8'h01);
      wr(SPICFG_REG_ADDR, 8'h40);
      rd(SPICFG_REG_ADDR, 8'h03, 8'h03);
      wr(SPICFG_REG_ADDR, 8'h00);
      pulse(4'h2);
      rd(SPICFG_REG_ADDR, 8'h00, 8'h01);
      pulse(4'h1);
      rd(SPICFG_REG_ADDR, 8'h01, 8'h01);
      pulse(4'h8);
      rd(SPICFG_REG_ADDR, 8'h00, 8'h02);
      pulse(4'h4);
      rd(SPICFG_REG_ADDR, 8'h02, 8'h02);
      start = 1'b1;
      repeat (10) @(negedge clock);
      rd(SPICFG_REG_ADDR, 8'h08, 8'h0C);
      repeat (70) @(negedge clock);
      rd(SPICFG_REG_ADDR, 8'h04, 8'h0E);
      check("strobes", strobes != 0, 8'h01);
      glitch = 1'b1;
      @(negedge clock);
      glitch = 1'b0;
      rd(SPICFG_REG_ADDR, 8'h00, 8'h0C);
      repeat (3) @(negedge clock);
      rd(SPICFG_REG_ADDR, 8'h04, 8'h0C);
      final_report();
   end
   // Watchdog far beyond the roughly 170 cycles the run needs
   initial
   begin
      #100000;
      errors++;
      final_report();
   end
endmodule
bind spicfg_reg spicfg_reg_checker u_checker (.clock, .reset, .sfr_addr, .sfr_write, .sfr_read,
   .sfr_wdata, .sfr_rdata, .ctrl, .sample_strobe, .sck_idle_level);
